/* File: design/ifm_pkg.sv */
// Purpose: constants and types for the interrupt flag and mask unit
// Assumes: apb slave with 32-bit data, one register per aligned word
// Notes: printed offsets are not multiples of four, so they are indices
package ifm_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [15:0] IFM_IDX_PT_MASK = 16'hffe2;
   localparam logic [15:0] IFM_IDX_SER_MASK = 16'hffe3;
   localparam logic [15:0] IFM_IDX_K0_MASK = 16'hffe4;
   localparam logic [15:0] IFM_IDX_K1_MASK = 16'hffe5;
   localparam logic [15:0] IFM_IDX_CT_MASK = 16'hffe6;
   localparam logic [15:0] IFM_IDX_SW_MASK = 16'hffe7;
   localparam logic [15:0] IFM_IDX_PT_FLAG = 16'hfff2;
   localparam logic [15:0] IFM_IDX_SER_FLAG = 16'hfff3;
   localparam logic [15:0] IFM_IDX_K0_FLAG = 16'hfff4;
   localparam logic [15:0] IFM_IDX_K1_FLAG = 16'hfff5;
   localparam logic [15:0] IFM_IDX_CT_FLAG = 16'hfff6;
   localparam logic [15:0] IFM_IDX_SW_FLAG = 16'hfff7;
   // flag/mask group index within the 6 groups (index low nibble minus 2)
   localparam int IFM_NGRP = 6;
   // implemented bits per group, unused bits read zero
   localparam logic [23:0] IFM_IMPL = {4'h3, 4'hf, 4'h1, 4'h1, 4'h1, 4'h3};
   localparam logic [3:0] IFM_RST_VAL = 4'h0;
   // vectors, highest priority first
   localparam logic [15:0] IFM_VEC_WDT = 16'h0100;
   localparam logic [15:0] IFM_VEC_PT = 16'h0104;
   localparam logic [15:0] IFM_VEC_SER = 16'h0106;
   localparam logic [15:0] IFM_VEC_K0 = 16'h0108;
   localparam logic [15:0] IFM_VEC_K1 = 16'h010a;
   localparam logic [15:0] IFM_VEC_CT = 16'h010c;
   localparam logic [15:0] IFM_VEC_SW = 16'h010e;

   // request to the cpu core
   typedef struct packed {
      logic req;
      logic nmi;
      logic [15:0] vector;
   } ifm_req_s;

   // sequencer states, gray along idle -> ack -> done
   typedef enum logic [1:0] {
      IFM_ST_IDLE = 2'b00,
      IFM_ST_ACK = 2'b01,
      IFM_ST_DONE = 2'b11
   } ifm_state_e;
endpackage

/* File: design/ifm_irq_unit.sv */
// Purpose: event flags, masks, gating, priority and vector for the cpu core
// Assumes: single 125 mhz clock, apb register access, sync active-low reset
// Notes: events arrive as one-cycle pulses from peripherals on this clock
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
module ifm_irq_unit
   import ifm_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [31:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // peripheral event pulses
   input wire logic [1:0] i_pt_evt,
   input wire logic i_ser_evt,
   input wire logic i_k0_evt,
   input wire logic i_k1_evt,
   input wire logic [3:0] i_ct_evt,
   input wire logic [1:0] i_sw_evt,
   input wire logic i_wdt_evt,
   // cpu core side
   input wire logic i_gie,
   input wire logic i_sp1_wr,
   input wire logic i_sp2_wr,
   input wire logic i_halted,
   input wire logic i_ack,
   output logic o_req,
   output logic o_nmi,
   output logic [15:0] o_vector,
   output logic o_clr_gie,
   output logic o_wake
);

   // storage is grouped by register: entry g serves the mask word at base+g
   // and the flag word at base+g, so one index decodes both tables
   // unused bit positions are never stored as ones, which keeps reads clean
   // without a separate read mask
   // state below is frozen whenever the clock enable is low and reset is released
   logic [3:0] flag_reg [IFM_NGRP]; // event flags per group
   logic [3:0] mask_reg [IFM_NGRP]; // mask bits per group
   logic sp1_seen_reg; // first stack pointer written
   logic sp2_seen_reg; // second stack pointer written
   logic nmi_pend_reg; // latched watchdog request
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   ifm_req_s req_reg;
   ifm_req_s req_next;
   logic clr_gie_reg;
   logic wake_reg;
   ifm_state_e state_reg;
   logic [3:0] evt [IFM_NGRP]; // events regrouped by register
   logic [15:0] idx; // register index from byte address
   logic acc_wr;
   logic acc_rd;
   logic sp_ok;
   logic [IFM_NGRP-1:0] grp_pend;

   // implemented bits of a group
   // used by the flag set and mask write paths alike, so kept in one place
   // a group with fewer sources simply has a narrower pattern here
   function automatic logic [3:0] impl_bits(input int g);
      impl_bits = IFM_IMPL[g*4 +: 4];
   endfunction

   // map a register index to group; returns 1 when it hits base+g
   // flag and mask tables share this test with different bases
   // the fixed 16 gap between the two bases is what keeps masks aligned
   function automatic logic grp_hit(input logic [15:0] i, input logic [15:0] base, input int g);
      grp_hit = (i == base + 16'(g));
   endfunction

   // byte address to word index; the two low bits are ignored on purpose
   // a transfer is taken only in the first access cycle, before ready
   // this makes a stretched access impossible to apply twice
   // stack pointer pair must be complete before anything is requested
   assign idx = i_paddr[17:2];
   assign acc_wr = i_psel & i_penable & i_pwrite & ~pready_reg;
   assign acc_rd = i_psel & i_penable & ~i_pwrite & ~pready_reg;
   assign sp_ok = sp1_seen_reg & sp2_seen_reg;

   // events arranged in register order, bit positions as mapped
   // events are single-cycle pulses on this clock, so no edge detect here
   // a pulse held longer only sets the flag again, which is harmless
   always_comb begin
      evt[0] = {2'b00, i_pt_evt};
      evt[1] = {3'b000, i_ser_evt};
      evt[2] = {3'b000, i_k0_evt};
      evt[3] = {3'b000, i_k1_evt};
      evt[4] = i_ct_evt;
      evt[5] = {2'b00, i_sw_evt};
   end

   // flags: set by event, cleared by write of one, set wins
   // a write of zero leaves a flag alone, so software may clear one source
   // without disturbing the others in the same word
   // the event is or-ed in last: a clear racing an event never loses it
   // flags are independent of masks and of the core's enable
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         for (int g = 0; g < IFM_NGRP; g++) begin
            flag_reg[g] <= IFM_RST_VAL;
         end
      end else if (i_ce) begin
         for (int g = 0; g < IFM_NGRP; g++) begin
            logic [3:0] clr;
            clr = '0;
            if (acc_wr && grp_hit(idx, IFM_IDX_PT_FLAG, g)) begin
               clr = i_pwdata[3:0];
            end
            // event or-in after clear so a same-cycle event survives
            flag_reg[g] <= ((flag_reg[g] & ~clr) | evt[g]) & impl_bits(g);
         end
      end
   end

   // masks: plain read/write, unused bits held at zero
   // masks only gate the request; they never touch the flags themselves
   // all sources start blocked after reset
   // writes outside the six mask words fall through with no effect
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         for (int g = 0; g < IFM_NGRP; g++) begin
            mask_reg[g] <= IFM_RST_VAL;
         end
      end else if (i_ce) begin
         for (int g = 0; g < IFM_NGRP; g++) begin
            if (acc_wr && grp_hit(idx, IFM_IDX_PT_MASK, g)) begin
               mask_reg[g] <= i_pwdata[3:0] & impl_bits(g);
            end
         end
      end
   end

   // apb answer: one wait state, read data from flags and masks
   // ready is a single-cycle pulse; it drops by itself on the next edge
   // read data is loaded with ready and held until the next read
   // no error response: an unmapped address simply reads zero
   // the wait state costs a cycle per access but keeps decode off the
   // path from address to read data
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else if (i_ce) begin
         pready_reg <= i_psel & i_penable & ~pready_reg;
         pslverr_reg <= 1'b0;
         if (acc_rd) begin
            // unmapped reads return zero without error
            prdata_reg <= 32'h0000_0000;
            for (int g = 0; g < IFM_NGRP; g++) begin
               if (grp_hit(idx, IFM_IDX_PT_FLAG, g)) begin
                  prdata_reg <= {28'h0000000, flag_reg[g]};
               end
               if (grp_hit(idx, IFM_IDX_PT_MASK, g)) begin
                  prdata_reg <= {28'h0000000, mask_reg[g]};
               end
            end
         end
      end
   end

   // stack pointer interlock: both must be written, one alone re-blocks
   // a pointer written a second time on its own restarts the pair, so
   // software that sets only one pointer keeps every request blocked,
   // the watchdog request included, until the partner follows
   // writes of both in one cycle complete the pair at once
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         sp1_seen_reg <= 1'b0;
         sp2_seen_reg <= 1'b0;
      end else if (i_ce) begin
         if (i_sp1_wr && i_sp2_wr) begin
            sp1_seen_reg <= 1'b1;
            sp2_seen_reg <= 1'b1;
         end else if (i_sp1_wr) begin
            // pair completes if the other was pending, else wait for it
            sp1_seen_reg <= 1'b1;
            sp2_seen_reg <= sp2_seen_reg & ~sp1_seen_reg;
         end else if (i_sp2_wr) begin
            sp2_seen_reg <= 1'b1;
            sp1_seen_reg <= sp1_seen_reg & ~sp2_seen_reg;
         end
      end
   end

   // watchdog request latched until the sequencer holds it in the ack state
   // there is no readable flag and no mask for this source
   // a new watchdog pulse in the same cycle as the clear keeps the latch
   // limitation: two watchdog events before the request reaches the ack state give one request
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         nmi_pend_reg <= 1'b0;
      end else if (i_ce) begin
         if (i_wdt_evt) begin
            nmi_pend_reg <= 1'b1;
         end else if (state_reg == IFM_ST_ACK && req_reg.nmi) begin
            nmi_pend_reg <= 1'b0;
         end
      end
   end

   // per group: any flag enabled by its mask
   // the core's enable is applied later, in the priority encoder
   always_comb begin
      for (int g = 0; g < IFM_NGRP; g++) begin
         grp_pend[g] = |(flag_reg[g] & mask_reg[g]);
      end
   end

   // priority encode and gating; flags stay, so request repeats
   // watchdog ranks first and ignores the enable; the others need it
   // within the maskable sources the order is fixed, group 0 highest
   // nothing at all is offered while the stack pointer pair is incomplete
   // fixed priority can starve low sources if software never clears flags
   always_comb begin
      req_next = '0;
      if (sp_ok) begin
         if (nmi_pend_reg) begin
            req_next = '{req: 1'b1, nmi: 1'b1, vector: IFM_VEC_WDT};
         end else if (i_gie) begin
            if (grp_pend[0]) begin
               req_next = '{req: 1'b1, nmi: 1'b0, vector: IFM_VEC_PT};
            end else if (grp_pend[1]) begin
               req_next = '{req: 1'b1, nmi: 1'b0, vector: IFM_VEC_SER};
            end else if (grp_pend[2]) begin
               req_next = '{req: 1'b1, nmi: 1'b0, vector: IFM_VEC_K0};
            end else if (grp_pend[3]) begin
               req_next = '{req: 1'b1, nmi: 1'b0, vector: IFM_VEC_K1};
            end else if (grp_pend[4]) begin
               req_next = '{req: 1'b1, nmi: 1'b0, vector: IFM_VEC_CT};
            end else if (grp_pend[5]) begin
               req_next = '{req: 1'b1, nmi: 1'b0, vector: IFM_VEC_SW};
            end
         end
      end
   end

   // acceptance sequencer: hold request until ack, then clear enable
   // the vector is latched at request time so a higher source arriving
   // later cannot change what the core is already fetching
   // the enable clear pulse tells the core to drop its enable, which
   // blocks further maskable requests until software raises it again
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         state_reg <= IFM_ST_IDLE;
         req_reg <= '0;
         clr_gie_reg <= 1'b0;
         wake_reg <= 1'b0;
      end else if (i_ce) begin
         clr_gie_reg <= 1'b0;
         // any live request restarts a halted core
         wake_reg <= i_halted & req_next.req;
         case (state_reg)
            IFM_ST_IDLE: begin
               req_reg <= req_next;
               if (req_next.req) begin
                  state_reg <= IFM_ST_ACK;
               end
            end
            IFM_ST_ACK: begin
               // vector stays frozen while the core finishes its instruction
               if (i_ack) begin
                  req_reg <= '0;
                  clr_gie_reg <= 1'b1;
                  state_reg <= IFM_ST_DONE;
               end
            end
            IFM_ST_DONE: begin
               // one idle cycle lets the core's enable drop before re-arbitration
               state_reg <= IFM_ST_IDLE;
            end
            default: begin
               state_reg <= IFM_ST_IDLE;
            end
         endcase
      end
   end

   // every output comes straight from a register, no logic after the flops
   // keeps output timing to the core and the bus master predictable
   // request fields are unpacked from the carrier struct here
   assign o_prdata = prdata_reg;
   assign o_pready = pready_reg;
   assign o_pslverr = pslverr_reg;
   assign o_req = req_reg.req;
   assign o_nmi = req_reg.nmi;
   assign o_vector = req_reg.vector;
   assign o_clr_gie = clr_gie_reg;
   assign o_wake = wake_reg;
endmodule

/* File: bench/ifm_irq_chk.sv */
// Purpose: port checks for the interrupt unit
// Assumes: one clock, sync active-low reset
// Notes: bound to each unit instance
`timescale 1ns/10ps
module ifm_irq_chk
   import ifm_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_gie,
   input wire logic i_halted,
   input wire logic i_ack,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_req,
   input wire logic o_nmi,
   input wire logic [15:0] o_vector,
   input wire logic o_clr_gie,
   input wire logic o_wake
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // one wait state, then a one-cycle ready
   property p_rdy; i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready; endproperty
   a_rdy: assert property (p_rdy) else $error("ready timing");
   property p_rd; o_pready |-> o_prdata[31:4] == 0 && !o_pslverr; endproperty
   a_rd: assert property (p_rd) else $error("read upper bits");
   // maskable request needs the enable one cycle before
   property p_gate; $rose(o_req) && !o_nmi |-> $past(i_gie); endproperty
   a_gate: assert property (p_gate) else $error("request without enable");
   property p_hold; o_req && !i_ack |=> o_req && $stable(o_vector) && $stable(o_nmi); endproperty
   a_hold: assert property (p_hold) else $error("request dropped");
   // ack ends request, enable clear pulses, one idle cycle
   property p_ack; o_req && i_ack |=> !o_req && o_clr_gie ##1 !o_clr_gie && !o_req; endproperty
   a_ack: assert property (p_ack) else $error("ack sequence");
   property p_clr; $rose(o_clr_gie) |-> $past(o_req && i_ack); endproperty
   a_clr: assert property (p_clr) else $error("stray enable clear");
   property p_nmi; o_req && o_nmi |-> o_vector == IFM_VEC_WDT; endproperty
   a_nmi: assert property (p_nmi) else $error("watchdog vector");
   property p_vec; o_req && !o_nmi |-> o_vector >= IFM_VEC_PT && o_vector <= IFM_VEC_SW && !o_vector[0]; endproperty
   a_vec: assert property (p_vec) else $error("bad vector");
   property p_wake; i_halted && $past(i_halted) && o_req && $past(o_req) |-> o_wake; endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   c_nmi: cover property (o_req && o_nmi);
   c_mask: cover property (o_req && !o_nmi && i_ack);
   c_wake: cover property (o_wake);
endmodule
bind ifm_irq_unit ifm_irq_chk u_chk (.*);

/* File: bench/ifm_cpu_model.sv */
// Purpose: cpu core stand-in taking requests
// Assumes: same clock as the unit
// Notes: ack delay is picked by the bench
`timescale 1ns/10ps
module ifm_cpu_model (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_req,
   input wire logic i_clr_gie,
   input wire logic i_ei,
   input wire logic i_di,
   input wire logic [3:0] i_dly,
   output logic o_ack,
   output logic o_gie
);
   logic [3:0] wait_reg; // cycles waited so far
   // one-cycle ack once the delay has run
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_ack <= 0;
         wait_reg <= 0;
      end else begin
         o_ack <= i_req && !o_ack && wait_reg == i_dly;
         wait_reg <= (i_req && !o_ack && wait_reg != i_dly) ? wait_reg + 4'h1 : 4'h0;
      end
   end
   // enable: dropped on acceptance, else software
   always_ff @(posedge i_clk) begin
      if (!i_nrst) o_gie <= 0;
      else if (i_clr_gie || i_di) o_gie <= 0;
      else if (i_ei) o_gie <= 1;
   end
endmodule

/* File: bench/interrupt_flag_mask_unit_test.sv */
// Purpose: self-checking bench for the interrupt unit
// Assumes: cpu model acks after a random delay
// Notes: flag and mask shadow predicts reads and vectors
`timescale 1ns/10ps
module interrupt_flag_mask_unit_test;
   import ifm_pkg::*;
   logic i_clk = 0, i_nrst = 0, psel = 0, penable = 0, pwrite = 0, halted = 0;
   logic ack, gie, pready, slverr, req, nmi, clr, wake;
   logic [3:0] ctl = 0, dly = 0; // ctl: di, ei, sp2, sp1
   logic [11:0] evv = 0; // all event pulses, wdt on top
   logic [31:0] paddr = 0, pwdata = 0, prdata, rd, seed = 75;
   logic [15:0] vec;
   int n_errors = 0, num_checks = 0;
   int flg[7], msk[6];
   int off[7] = '{0, 2, 3, 4, 5, 9, 11};
   always #4 i_clk = ~i_clk;
   ifm_irq_unit u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(slverr), .i_pt_evt(evv[1:0]), .i_ser_evt(evv[2]), .i_k0_evt(evv[3]), .i_k1_evt(evv[4]),
      .i_ct_evt(evv[8:5]), .i_sw_evt(evv[10:9]), .i_wdt_evt(evv[11]), .i_gie(gie), .i_sp1_wr(ctl[0]),
      .i_sp2_wr(ctl[1]), .i_halted(halted), .i_ack(ack), .o_req(req), .o_nmi(nmi), .o_vector(vec),
      .o_clr_gie(clr), .o_wake(wake));
   ifm_cpu_model u_cpu (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(req), .i_clr_gie(clr), .i_ei(ctl[2]),
      .i_di(ctl[3]), .i_dly(dly), .o_ack(ack), .o_gie(gie));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic int impl(int g);
      return int'(IFM_IMPL[4*g+:4]);
   endfunction
   // shadow arbitration, highest priority first
   function automatic logic [15:0] pick();
      for (int g = 0; g < 6; g++) if ((flg[g] & msk[g]) != 0) return 16'h0104 + 16'(2 * g);
      return 16'h0;
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // apb cycle; ev pulses the serial event at the write edge
   task automatic apb(input logic w, input logic [15:0] idx, input logic [3:0] d, input logic ev);
      int n;
      @(posedge i_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= {14'h0, idx, 2'b00};
      pwdata <= {28'h0, d};
      @(posedge i_clk);
      penable <= 1;
      evv[2] <= ev;
      n = 0;
      do begin
         @(posedge i_clk);
         evv[2] <= 0;
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) n_errors++;
      rd = prdata;
      chk(slverr, 0);
      psel <= 0;
      penable <= 0;
      if (w && idx[4]) flg[idx[3:0]-2] &= ~int'(d);
      if (w && !idx[4]) msk[idx[3:0]-2] = d & impl(idx[3:0]-2);
      if (ev) flg[1] |= 1;
   endtask
   task automatic rchk(input logic [15:0] idx, input int e);
      apb(0, idx, 0, 0);
      chk(rd, e);
   endtask
   task automatic ev(input int g, input int b);
      @(posedge i_clk);
      evv <= 12'(b << off[g]);
      @(posedge i_clk);
      evv <= 0;
      flg[g] |= b;
   endtask
   task automatic pulse(input logic [3:0] c);
      @(posedge i_clk);
      ctl <= c;
      @(posedge i_clk);
      ctl <= 0;
   endtask
   task automatic quiet(input int n);
      repeat (n) begin
         @(posedge i_clk);
         chk(req, 0);
      end
   endtask
   // wait for a request, compare, let the model accept it
   task automatic wreq(input logic m);
      int n;
      n = 0;
      while (req !== 1'b1 && n < 100) begin
         @(posedge i_clk);
         n++;
      end
      chk({req, nmi}, {1'b1, m});
      chk(wake, halted);
      chk(vec, m ? 16'h0100 : pick());
      while (req === 1'b1 && n < 200) begin
         @(posedge i_clk);
         n++;
      end
      dly <= 4'(xs() % 4);
      repeat (3) @(posedge i_clk);
      chk(gie, 0);
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge i_clk);
      i_nrst <= 1;
      for (int g = 0; g < 12; g++) rchk(16'hffe2 + 16'(g / 6 * 16 + g % 6), 0);
      rchk(16'hffe0, 0);
      pulse(4'h1); // one pointer only
      ev(6, 1);
      quiet(10);
      pulse(4'h2);
      wreq(1);
      for (int g = 0; g < 6; g++) begin
         apb(1, 16'hffe2 + 16'(g), 4'(xs()), 0);
         rchk(16'hffe2 + 16'(g), msk[g]);
         apb(1, 16'hffe2 + 16'(g), 0, 0);
      end
      for (int g = 0; g < 6; g++) ev(g, impl(g));
      pulse(4'h4);
      quiet(8);
      for (int g = 0; g < 6; g++) rchk(16'hfff2 + 16'(g), flg[g]);
      pulse(4'h8);
      halted <= 1;
      for (int g = 0; g < 6; g++) apb(1, 16'hffe2 + 16'(g), 4'hf, 0);
      pulse(4'h4);
      for (int g = 0; g < 6; g++) begin
         wreq(0);
         pulse(4'h4);
         wreq(0);
         apb(1, 16'hfff2 + 16'(g), 4'hf, 0);
         rchk(16'hfff2 + 16'(g), 0);
         pulse(4'h4);
      end
      halted <= 0;
      ev(1, 1);
      apb(1, 16'hfff3, 4'h1, 1);
      rchk(16'hfff3, flg[1]);
      give_verdict();
   end
   // about 400 cycles expected; cut off at 12500
   initial begin
      #100000;
      n_errors++;
      give_verdict();
   end
endmodule
